// ### verilog/tcr_pkg.sv
// constants, field layout and helpers for the transceiver configuration bank
// assumes a single digital clock domain; the serial framing sits outside this bank
package tcr_pkg;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [2:0] TCR_ADR_MODE_IRQ     = 3'h0;
  localparam logic [2:0] TCR_ADR_TUNING_LOW   = 3'h1;
  localparam logic [2:0] TCR_ADR_TUNING_HIGH  = 3'h2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] TCR_RST_MODE_IRQ     = 8'h80;
  localparam logic [7:0] TCR_RST_TUNING_LOW   = 8'hb0;
  localparam logic [7:0] TCR_RST_TUNING_HIGH  = 8'h7b;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TCR_IRQ_SEL_HI   = 7;
  localparam int TCR_IRQ_SEL_LO   = 6;
  localparam int TCR_ANA_EN_BIT   = 5;
  localparam int TCR_BAND_BIT     = 4;
  localparam int TCR_OPM_HI       = 2;
  localparam int TCR_OPM_LO       = 1;
  localparam int TCR_TRANSP_BIT   = 0;
  localparam int TCR_LOW_MSB      = 7;
  localparam int TCR_LOW_LSB      = 1;
  localparam int TCR_DUAL_BIT     = 0;
  localparam int TCR_HIGH_MSB     = 7;
  localparam int TCR_HIGH_LSB     = 2;
  localparam int TCR_SUPPLY_BIT   = 1;
  localparam int TCR_CLKOUT_BIT   = 0;
  localparam logic [7:0] TCR_MODE_IRQ_MASK = 8'hf7;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int TCR_TUNE_W       = 13;
  localparam int TCR_LOW_W        = 7;
  localparam int TCR_TUNE_RES_DIV = 16384;
  localparam int TCR_BUF_DEPTH    = 16;
  localparam int TCR_BUF_W        = 8;
  localparam int TCR_THR_STEP     = 4;

  typedef enum logic [1:0] {
    TCR_OPM_IDLE    = 2'b00,
    TCR_OPM_TX      = 2'b01,
    TCR_OPM_RX_POLL = 2'b10,
    TCR_OPM_RX      = 2'b11
  } tcr_opm_t;

  localparam logic [1:0] TCR_THR_NONE = 2'b11;

  // byte threshold for a select code: 00->4, 01->8, 10->12
  function automatic logic [4:0] tcr_thr_bytes(input logic [1:0] sel);
    tcr_thr_bytes = 5'(TCR_THR_STEP) * ({3'h0, sel} + 5'h01);
  endfunction : tcr_thr_bytes

  function automatic logic tcr_is_rx(input logic [1:0] opm);
    tcr_is_rx = (opm == TCR_OPM_RX_POLL) || (opm == TCR_OPM_RX);
  endfunction : tcr_is_rx

endpackage : tcr_pkg

// ### verilog/tcr_irq_eval.sv
// interrupt event evaluation for the shared data buffer
// assumes push/pop strobes and next fill level from the same clock domain
`timescale 1ns/1ns
module tcr_irq_eval (
  input  wire logic [1:0] opm_i,
  input  wire logic [1:0] thr_sel_i,
  input  wire logic       push_i,
  input  wire logic       pop_i,
  input  wire logic [4:0] count_d_i,
  input  wire logic       rx_error_i,
  input  wire logic       bit_check_ok_i,
  input  wire logic       dual_bit_i,
  output logic            irq_set_o
);
  import tcr_pkg::*;

  wire logic       is_rx    = tcr_is_rx(opm_i);
  wire logic       is_tx    = (opm_i == TCR_OPM_TX);
  wire logic       thr_on   = (thr_sel_i != TCR_THR_NONE);
  wire logic [4:0] thr      = tcr_thr_bytes(thr_sel_i);
  wire logic       rx_count = thr_on && push_i && (count_d_i == thr);
  wire logic       rx_evt   = rx_count || rx_error_i;
  wire logic       rx_chk   = bit_check_ok_i && !dual_bit_i;
  wire logic       tx_count = thr_on && pop_i && (count_d_i == thr);
  wire logic       tx_empty = pop_i && (count_d_i == 5'h00);

  assign irq_set_o = (is_rx && (rx_evt || rx_chk)) || (is_tx && (tx_count || tx_empty));

endmodule : tcr_irq_eval

// ### verilog/tcr_config_regs.sv
// transceiver configuration bank: control registers at indices 0..2 and data buffer
// assumes the serial frame decoder delivers one-cycle strobes on ref_clk_i
`timescale 1ns/1ns
module tcr_config_regs #(
  parameter int DEPTH = tcr_pkg::TCR_BUF_DEPTH,
  parameter int WIDTH = tcr_pkg::TCR_BUF_W
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [2:0]                  reg_addr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  output logic      [7:0]                  reg_rdata_o,
  input  wire logic                        buf_wr_i,
  input  wire logic [WIDTH-1:0]            buf_wdata_i,
  input  wire logic                        buf_rd_i,
  output logic      [WIDTH-1:0]            buf_rdata_o,
  input  wire logic                        rf_rx_valid_i,
  input  wire logic [WIDTH-1:0]            rf_rx_data_i,
  input  wire logic                        rf_tx_pop_i,
  output logic                             buf_full_o,
  output logic                             buf_empty_o,
  output logic      [4:0]                  buf_count_o,
  input  wire logic                        rx_error_i,
  input  wire logic                        bit_check_ok_i,
  input  wire logic                        push_button_inputs_i,
  input  wire logic                        power_on_flag_i,
  input  wire logic                        irq_ack_i,
  output logic                             irq_o,
  input  wire logic                        serial_in_tx_mod_pin_i,
  input  wire logic                        rf_rx_mod_i,
  output logic                             rf_tx_mod_o,
  output logic                             serial_out_rx_mod_pin_o,
  output logic                             serial_out_rx_mod_oe_o,
  output logic                             analog_supply_enable_o,
  output logic                             band_select_o,
  output logic      [1:0]                  operating_mode_o,
  output logic                             transparent_o,
  output logic                             manchester_enable_o,
  output logic [tcr_pkg::TCR_TUNE_W-1:0]   rf_tuning_word_o,
  output logic                             switched_supply_output_enable_o,
  output logic                             clock_output_enable_o
);
  import tcr_pkg::*;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [7:0] mode_irq_q;
  logic [7:0] tune_low_q;
  logic [7:0] tune_high_q;

  wire logic wr_mode = reg_wr_i && (reg_addr_i == TCR_ADR_MODE_IRQ);
  wire logic wr_low  = reg_wr_i && (reg_addr_i == TCR_ADR_TUNING_LOW);
  wire logic wr_high = reg_wr_i && (reg_addr_i == TCR_ADR_TUNING_HIGH);

  wire logic [1:0] opm      = mode_irq_q[TCR_OPM_HI:TCR_OPM_LO];
  wire logic [1:0] thr_sel  = mode_irq_q[TCR_IRQ_SEL_HI:TCR_IRQ_SEL_LO];
  wire logic       transp   = mode_irq_q[TCR_TRANSP_BIT];
  wire logic       dual_bit = tune_low_q[TCR_DUAL_BIT];
  wire logic       is_rx    = tcr_is_rx(opm);
  wire logic       is_tx    = (opm == TCR_OPM_TX);

  // forcing wins over a write in the same cycle, so a wake event is never lost
  wire logic force_on = (bit_check_ok_i && is_rx) || push_button_inputs_i
                        || power_on_flag_i;
  wire logic [7:0] high_wr_val = wr_high ? reg_wdata_i : tune_high_q;
  wire logic [7:0] force_mask  = force_on ? 8'h03 : 8'h00;
  wire logic [7:0] tune_high_d = high_wr_val | force_mask;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_irq_q  <= TCR_RST_MODE_IRQ;
      tune_low_q  <= TCR_RST_TUNING_LOW;
      tune_high_q <= TCR_RST_TUNING_HIGH;
    end else begin
      if (wr_mode) begin
        mode_irq_q <= reg_wdata_i & TCR_MODE_IRQ_MASK;
      end
      if (wr_low) begin
        tune_low_q <= reg_wdata_i;
      end
      tune_high_q <= tune_high_d;
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  wire logic [7:0] rd_mux = (reg_addr_i == TCR_ADR_MODE_IRQ)    ? mode_irq_q  :
                            (reg_addr_i == TCR_ADR_TUNING_LOW)  ? tune_low_q  :
                            (reg_addr_i == TCR_ADR_TUNING_HIGH) ? tune_high_q : 8'h00;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // decoded controls and tuning word
  // ------------------------------------------------------------
  wire logic [TCR_TUNE_W-1:0] low_part  = {6'h00, tune_low_q[TCR_LOW_MSB:TCR_LOW_LSB]};
  wire logic [TCR_TUNE_W-1:0] high_part = {tune_high_q[TCR_HIGH_MSB:TCR_HIGH_LSB], 7'h00};
  // step is crystal / TCR_TUNE_RES_DIV; the sum never carries since the fields are disjoint
  wire logic [TCR_TUNE_W-1:0] tune_sum  = low_part + high_part;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rf_tuning_word_o <= '0;
    end else begin
      rf_tuning_word_o <= tune_sum;
    end
  end

  assign analog_supply_enable_o          = mode_irq_q[TCR_ANA_EN_BIT];
  assign band_select_o                   = mode_irq_q[TCR_BAND_BIT];
  assign operating_mode_o                = opm;
  assign transparent_o                   = transp;
  assign manchester_enable_o             = is_tx && !dual_bit;
  assign switched_supply_output_enable_o = tune_high_q[TCR_SUPPLY_BIT];
  assign clock_output_enable_o           = tune_high_q[TCR_CLKOUT_BIT];

  // ------------------------------------------------------------
  // transparent path
  // ------------------------------------------------------------
  logic [1:0] sdi_sync_q;
  logic [1:0] rxm_sync_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sdi_sync_q <= 2'h0;
      rxm_sync_q <= 2'h0;
    end else begin
      sdi_sync_q <= {sdi_sync_q[0], serial_in_tx_mod_pin_i};
      rxm_sync_q <= {rxm_sync_q[0], rf_rx_mod_i};
    end
  end

  // two-cycle latency on each stream is the price of clean sampling
  assign rf_tx_mod_o             = transp && is_tx && sdi_sync_q[1];
  assign serial_out_rx_mod_pin_o = transp && is_rx && rxm_sync_q[1];
  assign serial_out_rx_mod_oe_o  = transp && is_rx;

  // ------------------------------------------------------------
  // shared data buffer
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [3:0]       wr_ptr_q;
  logic [3:0]       rd_ptr_q;
  logic [4:0]       count_q;

  // a mode change flushes stale payload of the other direction
  wire logic       flush    = wr_mode && (reg_wdata_i[TCR_OPM_HI:TCR_OPM_LO] != opm);
  wire logic       src_wr   = is_tx ? buf_wr_i : (is_rx && rf_rx_valid_i);
  wire logic       src_rd   = is_tx ? rf_tx_pop_i : (is_rx && buf_rd_i);
  wire logic [WIDTH-1:0] src_data = is_tx ? buf_wdata_i : rf_rx_data_i;
  wire logic       push     = src_wr && !transp && !buf_full_o;
  wire logic       pop      = src_rd && !transp && !buf_empty_o;
  wire logic [4:0] count_d  = count_q + {4'h0, push} - {4'h0, pop};

  assign buf_full_o  = (count_q == 5'(DEPTH));
  assign buf_empty_o = (count_q == 5'h00);
  assign buf_count_o = count_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
    end else if (flush) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + 4'h1 : wr_ptr_q;
      rd_ptr_q <= pop  ? rd_ptr_q + 4'h1 : rd_ptr_q;
      count_q  <= count_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= src_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_rdata_o <= '0;
    end else if (pop) begin
      buf_rdata_o <= mem_q[rd_ptr_q];
    end
  end

  // ------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------
  logic irq_set;

  tcr_irq_eval u_irq_eval (
    .opm_i          (opm),
    .thr_sel_i      (thr_sel),
    .push_i         (push),
    .pop_i          (pop),
    .count_d_i      (count_d),
    .rx_error_i     (rx_error_i),
    .bit_check_ok_i (bit_check_ok_i),
    .dual_bit_i     (dual_bit),
    .irq_set_o      (irq_set)
  );

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_set || (irq_o && !irq_ack_i);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_rx_fill;
    is_rx && (thr_sel != TCR_THR_NONE) && push && (count_d == tcr_thr_bytes(thr_sel));
  endsequence

  sequence s_tx_drain;
    is_tx && pop && !push && (count_q == 5'h01);
  endsequence

  chk_rx_thresh_irq: assert property (s_rx_fill |=> irq_o)
    else $error("rx byte threshold did not raise irq");
  chk_rx_error_irq: assert property (is_rx && rx_error_i |=> irq_o)
    else $error("rx error did not raise irq");
  chk_rx_sel3_quiet: assert property (is_rx && (thr_sel == TCR_THR_NONE) && !rx_error_i
      && !(bit_check_ok_i && !dual_bit) && (!irq_o || irq_ack_i) |=> !irq_o)
    else $error("irq raised without rx error under select 11");
  chk_tx_empty_irq: assert property (s_tx_drain |=> irq_o && buf_empty_o)
    else $error("tx buffer emptied without irq");
  chk_tx_remain_irq: assert property (is_tx && pop && (thr_sel != TCR_THR_NONE)
      && !push && (count_q == tcr_thr_bytes(thr_sel) + 5'h01) |=> irq_o)
    else $error("tx remaining threshold did not raise irq");
  chk_check_masked: assert property (is_rx && bit_check_ok_i && dual_bit && !rx_error_i
      && !push && !irq_o |=> !irq_o)
    else $error("masked bit check raised irq");
  chk_supply_force: assert property (push_button_inputs_i || power_on_flag_i
      |=> switched_supply_output_enable_o)
    else $error("supply enable not forced on");
  chk_tuning_sum: assert property (wr_low || wr_high
      |=> ##1 rf_tuning_word_o == {$past(tune_high_q[7:2]), $past(tune_low_q[7:1])})
    else $error("tuning word not refreshed after write");
  chk_transp_bypass: assert property (transp && !flush |=> $stable(count_q))
    else $error("buffer moved in transparent mode");
  chk_tx_coding: assert property (wr_low && is_tx
      |=> manchester_enable_o == !$past(reg_wdata_i[TCR_DUAL_BIT]))
    else $error("manchester coding does not follow dual bit write");
  chk_mode_write: assert property (wr_mode && !force_on
      |=> opm == $past(reg_wdata_i[2:1]))
    else $error("operating mode not taken from write");
  chk_rx_check_irq: assert property (is_rx && bit_check_ok_i && !dual_bit
      |=> irq_o)
    else $error("successful bit check did not raise irq");
  chk_irq_sticky: assert property (irq_o && !irq_ack_i |=> irq_o)
    else $error("irq dropped without acknowledge");
  chk_force_wins: assert property (wr_high && force_on
      |=> switched_supply_output_enable_o && clock_output_enable_o)
    else $error("forced supply bits lost to a write");
  chk_flush_empty: assert property (flush |=> buf_empty_o)
    else $error("mode change did not flush buffer");
  chk_full_refuse: assert property (buf_full_o && !pop && !flush |=> buf_full_o)
    else $error("full buffer changed without pop");
  chk_unmapped_write: assert property (reg_wr_i && (reg_addr_i > TCR_ADR_TUNING_HIGH)
      |=> $stable(mode_irq_q) && $stable(tune_low_q))
    else $error("write to unmapped index changed a register");

endmodule : tcr_config_regs

// ### test/tcr_mcu_model.sv
// controller model driving the register strobes of the configuration bank
// assumes the bench clock; changes its outputs only just after falling edges
`timescale 1ns/1ns
module tcr_mcu_model (
  input  wire logic       clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic [2:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i
);
  // ------------------------------------------------------------
  // register cycles
  // ------------------------------------------------------------
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 3'h7;
    wdata_o = 8'h00;
  end

  // no auxiliary supply mode here, so clearing supply enable is legal
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : write

  task automatic read(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : read
endmodule : tcr_mcu_model

// ### test/tb_top.sv
// self-checking bench for the transceiver configuration bank
// assumes tcr_pkg, the design and the controller model are compiled first
`timescale 1ns/1ns
module tb_top;
  import tcr_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        ref_clk_i;
  logic        reset_n_i;
  logic [7:0]  strb;
  logic [7:0]  din;
  logic        sdi_pin;
  logic        rx_mod;
  logic        pwr_flag;
  logic        mw;
  logic        mr;
  logic [2:0]  ma;
  logic [7:0]  md;
  logic [7:0]  mq;
  logic [7:0]  rm [3];
  logic [7:0]  q [$];
  logic [31:0] seed = 32'h00008616;
  int          errors = 0;
  int          checks = 0;

  tcr_config_regs dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(mw), .reg_rd_i(mr),
    .reg_addr_i(ma), .reg_wdata_i(md), .reg_rdata_o(mq), .buf_wr_i(strb[1]),
    .buf_wdata_i(din), .buf_rd_i(strb[2]), .buf_rdata_o(), .rf_rx_valid_i(strb[0]),
    .rf_rx_data_i(din), .rf_tx_pop_i(strb[3]), .buf_full_o(), .buf_empty_o(),
    .buf_count_o(), .rx_error_i(strb[4]), .bit_check_ok_i(strb[5]),
    .push_button_inputs_i(strb[6]), .power_on_flag_i(pwr_flag), .irq_ack_i(strb[7]),
    .irq_o(), .serial_in_tx_mod_pin_i(sdi_pin), .rf_rx_mod_i(rx_mod), .rf_tx_mod_o(),
    .serial_out_rx_mod_pin_o(), .serial_out_rx_mod_oe_o(), .analog_supply_enable_o(),
    .band_select_o(), .operating_mode_o(), .transparent_o(), .manchester_enable_o(),
    .rf_tuning_word_o(), .switched_supply_output_enable_o(), .clock_output_enable_o());

  tcr_mcu_model mcu (.clk_i(ref_clk_i), .wr_o(mw), .rd_o(mr), .addr_o(ma), .wdata_o(md),
                     .rdata_i(mq));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // tuning word is the plain sum of both parts
  function automatic logic [12:0] tune(input logic [7:0] lo, input logic [7:0] hi);
    return {6'h00, lo[7:1]} + {hi[7:2], 7'h00};
  endfunction : tune

  // select 11 has no byte threshold at all
  function automatic int thr(input int s);
    return (s == 3) ? -1 : 4 * (s + 1);
  endfunction : thr

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // one-cycle strobe, then one more edge so a raised interrupt has landed
  task automatic pulse(input int k, input logic [7:0] d);
    @(negedge ref_clk_i);
    strb = 8'h01 << k;
    din = d;
    @(negedge ref_clk_i);
    strb = 8'h00;
    din = ~d;
    @(negedge ref_clk_i);
  endtask : pulse

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    mcu.read(a, v);
    check("register", {8'h00, v}, {8'h00, e});
  endtask : rd_chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    mcu.write(a, d);
    if (a < 3'h3) begin
      rm[a] = (a == 3'h0) ? (d & TCR_MODE_IRQ_MASK) : d;
    end
    repeat (2) @(negedge ref_clk_i);
  endtask : wr

  // going through idle flushes the buffer; the ack drops any stale interrupt
  task automatic mode(input logic [7:0] v);
    wr(3'h0, 8'h00);
    wr(3'h0, v);
    pulse(7, 8'h00);
  endtask : mode

  task automatic fields();
    check("analog", dut.analog_supply_enable_o, rm[0][5]);
    check("band", dut.band_select_o, rm[0][4]);
    check("opm", dut.operating_mode_o, rm[0][2:1]);
    check("transp", dut.transparent_o, rm[0][0]);
    check("manch", dut.manchester_enable_o, rm[0][2:1] == 2'b01 && !rm[1][0]);
    check("tune", dut.rf_tuning_word_o, tune(rm[1], rm[2]));
    check("supply", dut.switched_supply_output_enable_o, rm[2][1]);
    check("clkout", dut.clock_output_enable_o, rm[2][0]);
  endtask : fields

  initial begin
    repeat (30000) @(posedge ref_clk_i);
    errors++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] tmp;
    int n;
    strb = 8'h00;
    din = 8'h00;
    sdi_pin = 1'b0;
    rx_mod = 1'b0;
    pwr_flag = 1'b0;
    reset_n_i = 1'b0;
    rm[0] = TCR_RST_MODE_IRQ;
    rm[1] = TCR_RST_TUNING_LOW;
    rm[2] = TCR_RST_TUNING_HIGH;
    repeat (12) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check("tune_rst", dut.rf_tuning_word_o, 13'h0f00 + 13'h0058);
    for (int a = 0; a < 3; a++) begin
      rd_chk(a[2:0], rm[a]);
    end
    fields();
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      tmp = rnd();
      wr(tmp[2:0], tmp[15:8]);
      rd_chk(tmp[2:0], (tmp[2:0] < 3'h3) ? rm[tmp[2:0]] : 8'h00);
      fields();
    end
    $display("test random registers done");
    for (int s = 0; s < 4; s++) begin
      mode({s[1:0], 6'h06});
      check("sdo_oe", dut.serial_out_rx_mod_oe_o, 1'b0);
      n = (s == 3) ? 16 : thr(s);
      for (int i = 0; i < n; i++) begin
        check("irq_rx", dut.irq_o, 1'b0);
        tmp = rnd();
        pulse(0, tmp[7:0]);
        q.push_back(tmp[7:0]);
      end
      check("irq_rx", dut.irq_o, s != 3);
      if (s == 3) begin
        check("full", dut.buf_full_o, 1'b1);
        pulse(0, 8'h5a);
        check("count", dut.buf_count_o, 5'h10);
      end
      pulse(7, 8'h00);
      pulse(4, 8'h00);
      check("irq_err", dut.irq_o, 1'b1);
      pulse(7, 8'h00);
      while (q.size() > 0) begin
        pulse(2, 8'h00);
        check("rx_data", dut.buf_rdata_o, q.pop_front());
      end
      check("empty", dut.buf_empty_o, 1'b1);
    end
    wr(3'h1, 8'hb0);
    pulse(5, 8'h00);
    check("irq_bchk", dut.irq_o, 1'b1);
    wr(3'h1, 8'hb1);
    pulse(7, 8'h00);
    pulse(5, 8'h00);
    check("irq_bchk", dut.irq_o, 1'b0);
    for (int k = 5; k < 8; k++) begin
      wr(3'h2, 8'h78);
      check("supply", dut.switched_supply_output_enable_o, 1'b0);
      if (k < 7) begin
        pulse(k, 8'h00);
      end else begin
        pwr_flag = 1'b1;
      end
      repeat (2) @(negedge ref_clk_i);
      rm[2] = 8'h7b;
      rd_chk(3'h2, rm[2]);
    end
    wr(3'h2, 8'h78);
    rm[2] = 8'h7b;
    rd_chk(3'h2, rm[2]);
    pwr_flag = 1'b0;
    $display("test rx and force done");
    for (int s = 0; s < 4; s++) begin
      mode({s[1:0], 6'h02});
      wr(3'h1, {7'h58, s[0]});
      fields();
      for (int i = 0; i < 13; i++) begin
        tmp = rnd();
        pulse(1, tmp[7:0]);
        q.push_back(tmp[7:0]);
      end
      pulse(7, 8'h00);
      for (int r = 12; r >= 0; r--) begin
        pulse(3, 8'h00);
        check("tx_data", dut.buf_rdata_o, q.pop_front());
        check("count", dut.buf_count_o, r[4:0]);
        check("irq_tx", dut.irq_o, r == 0 || r == thr(s));
        pulse(7, 8'h00);
      end
    end
    $display("test tx thresholds done");
    for (int t = 0; t < 2; t++) begin
      mode(t ? 8'h87 : 8'h83);
      pulse(t ? 0 : 1, 8'h11);
      check("count", dut.buf_count_o, 5'h00);
      for (int b = 0; b < 2; b++) begin
        sdi_pin = ~b[0];
        rx_mod = ~b[0];
        repeat (4) @(negedge ref_clk_i);
        check("mod_out", t ? dut.serial_out_rx_mod_pin_o : dut.rf_tx_mod_o, !b[0]);
      end
    end
    check("sdo_oe", dut.serial_out_rx_mod_oe_o, 1'b1);
    $display("test transparent done");
    // mid-run reset must bring every register back to its default
    reset_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    rm[0] = TCR_RST_MODE_IRQ;
    rm[1] = TCR_RST_TUNING_LOW;
    rm[2] = TCR_RST_TUNING_HIGH;
    repeat (2) @(negedge ref_clk_i);
    check("count", dut.buf_count_o, 5'h00);
    check("irq", dut.irq_o, 1'b0);
    for (int a = 0; a < 3; a++) begin
      rd_chk(a[2:0], rm[a]);
    end
    fields();
    $display("test mid reset done");
    conclude();
  end
endmodule : tb_top
